// >>> design/tmps_pkg.sv
package tmps_pkg;

    // ==========================================================
    // Channel geometry
    // ==========================================================
    localparam int unsigned NUM_CHANNELS   = 128;
    localparam int unsigned CHAN_PER_BLOCK = 16;
    localparam int unsigned CHAN_W         = 7;
    localparam int unsigned SLOT_W         = 4;
    localparam int unsigned BLOCK_W        = 3;
    localparam int unsigned FLEN_W         = 7;

    localparam logic [SLOT_W-1:0]  SLOT_LAST     = 4'hF;
    localparam logic [BLOCK_W-1:0] BLOCK_ZERO    = 3'h0;
    localparam logic [BLOCK_W-1:0] BLOCK_ONE     = 3'h1;
    localparam logic [CHAN_W-1:0]  CHAN_ZERO     = 7'h00;
    localparam logic [CHAN_PER_BLOCK-1:0] EN_NONE = 16'h0000;

    // ==========================================================
    // Mode encodings
    // ==========================================================
    localparam logic [1:0] TX_MODE_ALL    = 2'h0;
    localparam logic [1:0] TX_MODE_ENABLE = 2'h1;
    localparam logic [1:0] TX_MODE_MASK   = 2'h2;
    localparam logic [1:0] TX_MODE_SYM    = 2'h3;
    localparam logic [1:0] IRQ_MODE_BLOCK = 2'h1;

    // ==========================================================
    // Carriers
    // ==========================================================
    // Static configuration of one direction
    typedef struct packed {
        logic              phase_select;
        logic [FLEN_W-1:0] frame_length;
        logic              partition_count_sel;
        logic [1:0]        multichan_mode;
        logic [1:0]        irq_mode;
        logic [1:0]        part_a_block;
        logic [1:0]        part_b_block;
    } tmps_dir_cfg_t;

    // Per-slot decision handed to the serial datapath
    typedef struct packed {
        logic              slot_valid;
        logic [CHAN_W-1:0] channel;
        logic              enabled;
        logic              unmasked;
    } tmps_slot_t;

    // Partition sequencer state
    typedef enum logic [1:0] {
        TMPS_IDLE   = 2'b00,
        TMPS_RUN    = 2'b01,
        TMPS_FINISH = 2'b10
    } tmps_state_t;

endpackage

// >>> design/tmps_sync.sv
`timescale 1ns/1ps
`default_nettype none
// Two-flop synchroniser for a level
module tmps_sync
    import tmps_pkg::*;
#(
    parameter int unsigned WIDTH = 1
)(
    input  wire logic             clk,
    input  wire logic             reset_n,
    input  wire logic [WIDTH-1:0] async_in,
    output logic      [WIDTH-1:0] sync_out
);

    logic [WIDTH-1:0] meta_q;

    // ==========================================================
    // Sync chain
    // ==========================================================
    // First stage feeds only the second stage
    always_ff @(posedge clk or negedge reset_n)
    begin
        if (!reset_n)
        begin
            meta_q   <= '0;
            sync_out <= '0;
        end
        else
        begin
            meta_q   <= async_in;
            sync_out <= meta_q;
        end
    end

endmodule
`default_nettype wire

// >>> design/tmps_toggle_sync.sv
`timescale 1ns/1ps
`default_nettype none
// Pulse crossing by toggle; source toggles, sink sees one pulse per toggle
module tmps_toggle_sync
    import tmps_pkg::*;
(
    input  wire logic clk,
    input  wire logic reset_n,
    input  wire logic toggle_in,
    output logic      pulse_out
);

    logic meta_q;
    logic sync_q;
    logic last_q;

    // ==========================================================
    // Toggle to pulse
    // ==========================================================
    // Edge detect compares the second and third stages, never the first
    always_ff @(posedge clk or negedge reset_n)
    begin
        if (!reset_n)
        begin
            meta_q    <= 1'b0;
            sync_q    <= 1'b0;
            last_q    <= 1'b0;
            pulse_out <= 1'b0;
        end
        else
        begin
            meta_q    <= toggle_in;
            sync_q    <= meta_q;
            last_q    <= sync_q;
            pulse_out <= sync_q ^ last_q;
        end
    end

endmodule
`default_nettype wire

// >>> design/tmps_partition_select.sv
`timescale 1ns/1ps
`default_nettype none
module tmps_partition_select
    import tmps_pkg::*;
(
    input  wire logic                      sys_clk,
    input  wire logic                      reset_n,
    input  wire logic                      bit_clk,
    input  wire logic                      rx_frame_sync,
    input  wire logic                      rx_slot_end,
    input  wire logic                      tx_frame_sync,
    input  wire logic                      tx_slot_end,
    input  wire tmps_dir_cfg_t             rx_cfg,
    input  wire tmps_dir_cfg_t             tx_cfg,
    input  wire logic [NUM_CHANNELS-1:0]   rx_chan_enable,
    input  wire logic [NUM_CHANNELS-1:0]   tx_chan_enable,
    output tmps_slot_t                     rx_slot,
    output tmps_slot_t                     tx_slot,
    output logic                           rx_copy_allowed,
    output logic                           tx_copy_allowed,
    output logic                           tx_drive_n,
    output logic [BLOCK_W-1:0]             rx_current_block,
    output logic [BLOCK_W-1:0]             tx_current_block,
    output logic                           rx_block_irq,
    output logic                           tx_block_irq
);

    // ==========================================================
    // Configuration into the link domain
    // ==========================================================
    // Config is quasi-static; software changes only the inactive
    // partition, so a bitwise two-flop crossing is safe here.
    localparam int unsigned CFG_W = $bits(tmps_dir_cfg_t);

    tmps_dir_cfg_t             rx_cfg_l;
    tmps_dir_cfg_t             tx_cfg_l;
    logic [NUM_CHANNELS-1:0]   rx_en_l;
    logic [NUM_CHANNELS-1:0]   tx_en_l;

    tmps_sync #(.WIDTH(CFG_W)) u_rx_cfg_sync (
        .clk      (bit_clk),
        .reset_n  (reset_n),
        .async_in (rx_cfg),
        .sync_out (rx_cfg_l)
    );

    tmps_sync #(.WIDTH(CFG_W)) u_tx_cfg_sync (
        .clk      (bit_clk),
        .reset_n  (reset_n),
        .async_in (tx_cfg),
        .sync_out (tx_cfg_l)
    );

    tmps_sync #(.WIDTH(NUM_CHANNELS)) u_rx_en_sync (
        .clk      (bit_clk),
        .reset_n  (reset_n),
        .async_in (rx_chan_enable),
        .sync_out (rx_en_l)
    );

    tmps_sync #(.WIDTH(NUM_CHANNELS)) u_tx_en_sync (
        .clk      (bit_clk),
        .reset_n  (reset_n),
        .async_in (tx_chan_enable),
        .sync_out (tx_en_l)
    );

    // ==========================================================
    // Block decode helpers
    // ==========================================================
    // Block of a partition index: fixed in eight-partition mode,
    // otherwise A even and B odd from the assignment fields
    function automatic logic [BLOCK_W-1:0] part_block(
        input logic [BLOCK_W-1:0] part,
        input logic               eight_mode,
        input logic [1:0]         a_blk,
        input logic [1:0]         b_blk
    );
        logic [BLOCK_W-1:0] blk;
        blk = part;
        if (!eight_mode)
        begin
            if (part[0])
                blk = {b_blk, 1'b1};
            else
                blk = {a_blk, 1'b0};
        end
        return blk;
    endfunction

    // Next partition: alternate A/B or step A..H
    function automatic logic [BLOCK_W-1:0] next_part(
        input logic [BLOCK_W-1:0] part,
        input logic               eight_mode
    );
        logic [BLOCK_W-1:0] nxt;
        nxt = part + BLOCK_ONE;
        if (!eight_mode)
            nxt = {2'b00, ~part[0]};
        return nxt;
    endfunction

    // ==========================================================
    // Per-direction sequencer in the link domain
    // ==========================================================
    // Direction 0 is receive, 1 is transmit; both share the logic
    // but keep their own partition count
    logic [1:0]                cur_irq_tgl;
    logic [1:0]                st_en;
    logic [1:0]                st_unm;
    logic [1:0]                st_valid;
    logic [CHAN_W-1:0]         st_chan [2];
    logic [BLOCK_W-1:0]        st_blk  [2];
    logic [CHAN_PER_BLOCK-1:0] rx_blk_en_w;

    genvar gd;
    generate
        for (gd = 0; gd < 2; gd = gd + 1)
        begin : g_dir
            tmps_dir_cfg_t             cfg;
            logic [NUM_CHANNELS-1:0]   en_vec;
            logic                      fs;
            logic                      se;
            tmps_state_t               state_q;
            tmps_state_t               state_d;
            logic [BLOCK_W-1:0]        part_q;
            logic [BLOCK_W-1:0]        part_d;
            logic [SLOT_W-1:0]         slot_q;
            logic [CHAN_W-1:0]         frame_pos_q;
            logic [BLOCK_W-1:0]        blk_q;
            logic [CHAN_PER_BLOCK-1:0] blk_en_q;
            logic                      irq_tgl_q;
            logic                      block_end;
            logic                      frame_end;
            logic [BLOCK_W-1:0]        start_blk;
            logic [BLOCK_W-1:0]        nxt_blk;

            assign cfg    = (gd == 0) ? rx_cfg_l : tx_cfg_l;
            assign en_vec = (gd == 0) ? rx_en_l : tx_en_l;
            assign fs     = (gd == 0) ? rx_frame_sync : tx_frame_sync;
            assign se     = (gd == 0) ? rx_slot_end : tx_slot_end;

            // Frame ends after frame_length+1 slots
            assign frame_end = se && (frame_pos_q == cfg.frame_length);
            assign block_end = se && ((slot_q == SLOT_LAST) || frame_end);
            assign part_d    = next_part(part_q, cfg.partition_count_sel);
            assign start_blk = part_block(BLOCK_ZERO,
                                          cfg.partition_count_sel,
                                          cfg.part_a_block,
                                          cfg.part_b_block);
            assign nxt_blk   = part_block(part_d,
                                          cfg.partition_count_sel,
                                          cfg.part_a_block,
                                          cfg.part_b_block);

            // State decode
            always_comb
            begin
                state_d = state_q;
                case (state_q)
                    TMPS_IDLE:   if (fs) state_d = TMPS_RUN;
                    TMPS_RUN:    if (frame_end && !fs) state_d = TMPS_FINISH;
                    TMPS_FINISH: if (fs) state_d = TMPS_RUN;
                    default:     state_d = TMPS_IDLE;
                endcase
            end

            // Sync restarts at partition A; each new partition latches
            // its block and enable bits on entry
            always_ff @(posedge bit_clk or negedge reset_n)
            begin
                if (!reset_n)
                begin
                    state_q     <= TMPS_IDLE;
                    part_q      <= BLOCK_ZERO;
                    slot_q      <= '0;
                    frame_pos_q <= CHAN_ZERO;
                    blk_q       <= BLOCK_ZERO;
                    blk_en_q    <= EN_NONE;
                    irq_tgl_q   <= 1'b0;
                end
                else
                begin
                    state_q <= state_d;
                    if (fs)
                    begin
                        part_q      <= BLOCK_ZERO;
                        slot_q      <= '0;
                        frame_pos_q <= CHAN_ZERO;
                        blk_q       <= start_blk;
                        blk_en_q    <= en_vec[start_blk*CHAN_PER_BLOCK
                                              +: CHAN_PER_BLOCK];
                    end
                    else if (se && state_q == TMPS_RUN)
                    begin
                        slot_q      <= slot_q + 4'h1;
                        frame_pos_q <= frame_pos_q + 7'h01;
                        if (block_end && !frame_end)
                        begin
                            part_q   <= part_d;
                            slot_q   <= '0;
                            blk_q    <= nxt_blk;
                            blk_en_q <= en_vec[nxt_blk*CHAN_PER_BLOCK
                                               +: CHAN_PER_BLOCK];
                        end
                    end
                    // Block end event in interrupt mode 01b
                    if (block_end && state_q == TMPS_RUN
                        && cfg.irq_mode == IRQ_MODE_BLOCK)
                        irq_tgl_q <= ~irq_tgl_q;
                end
            end

            assign cur_irq_tgl[gd] = irq_tgl_q;
            assign st_valid[gd]    = (state_q == TMPS_RUN);
            assign st_chan[gd]     = {blk_q, slot_q};
            assign st_blk[gd]      = blk_q;
            assign st_en[gd]       = blk_en_q[slot_q];
            assign st_unm[gd]      = blk_en_q[slot_q];
        end
    endgenerate

    // Receive enable bits of the current transmit slot for symmetric mode
    assign rx_blk_en_w = rx_en_l[st_blk[1]*CHAN_PER_BLOCK +: CHAN_PER_BLOCK];

    // ==========================================================
    // Per-slot gating
    // ==========================================================
    // Receive: mode 0 passes all slots; mode 1 uses enable bits.
    // Only two blocks are live per frame in two-partition mode, so
    // at most 32 channels pass.
    logic rx_en_w;
    logic tx_en_w;
    logic tx_unm_w;

    assign rx_en_w = !rx_cfg_l.multichan_mode[0] || st_en[0];

    // Transmit mode table
    always_comb
    begin
        tx_en_w  = 1'b1;
        tx_unm_w = 1'b1;
        case (tx_cfg_l.multichan_mode)
            TX_MODE_ALL:
            begin
                tx_en_w  = 1'b1;
                tx_unm_w = 1'b1;
            end
            TX_MODE_ENABLE:
            begin
                tx_en_w  = st_en[1];
                tx_unm_w = st_en[1];
            end
            TX_MODE_MASK:
            begin
                tx_en_w  = 1'b1;
                tx_unm_w = st_unm[1];
            end
            TX_MODE_SYM:
            begin
                tx_en_w  = rx_blk_en_w[st_chan[1][SLOT_W-1:0]];
                tx_unm_w = tx_en_w && st_unm[1];
            end
            default:
            begin
                tx_en_w  = 1'b0;
                tx_unm_w = 1'b0;
            end
        endcase
    end

    // Link-side registered outputs; a disabled receive slot gets no
    // copy out of the shift buffer, hence no ready flag or event
    always_ff @(posedge bit_clk or negedge reset_n)
    begin
        if (!reset_n)
        begin
            rx_slot         <= '0;
            tx_slot         <= '0;
            rx_copy_allowed <= 1'b0;
            tx_copy_allowed <= 1'b0;
            tx_drive_n      <= 1'b1;
        end
        else
        begin
            rx_slot         <= '{st_valid[0], st_chan[0], rx_en_w, 1'b1};
            tx_slot         <= '{st_valid[1], st_chan[1], tx_en_w, tx_unm_w};
            rx_copy_allowed <= st_valid[0] && rx_en_w;
            tx_copy_allowed <= st_valid[1] && tx_en_w;
            tx_drive_n      <= !(st_valid[1] && tx_unm_w);    // Masked: float
        end
    end

    // ==========================================================
    // Status and events into the system domain
    // ==========================================================
    // Block number moves only at partition boundaries, so the two-flop
    // copy can be off by one boundary for two cycles at most
    logic [BLOCK_W-1:0] rx_blk_s;
    logic [BLOCK_W-1:0] tx_blk_s;
    logic               rx_irq_p;
    logic               tx_irq_p;

    tmps_sync #(.WIDTH(BLOCK_W)) u_rx_blk_sync (
        .clk      (sys_clk),
        .reset_n  (reset_n),
        .async_in (st_blk[0]),
        .sync_out (rx_blk_s)
    );

    tmps_sync #(.WIDTH(BLOCK_W)) u_tx_blk_sync (
        .clk      (sys_clk),
        .reset_n  (reset_n),
        .async_in (st_blk[1]),
        .sync_out (tx_blk_s)
    );

    tmps_toggle_sync u_rx_irq_sync (
        .clk       (sys_clk),
        .reset_n   (reset_n),
        .toggle_in (cur_irq_tgl[0]),
        .pulse_out (rx_irq_p)
    );

    tmps_toggle_sync u_tx_irq_sync (
        .clk       (sys_clk),
        .reset_n   (reset_n),
        .toggle_in (cur_irq_tgl[1]),
        .pulse_out (tx_irq_p)
    );

    // System-side registered status and block-end pulses
    always_ff @(posedge sys_clk or negedge reset_n)
    begin
        if (!reset_n)
        begin
            rx_current_block <= BLOCK_ZERO;
            tx_current_block <= BLOCK_ZERO;
            rx_block_irq     <= 1'b0;
            tx_block_irq     <= 1'b0;
        end
        else
        begin
            rx_current_block <= rx_blk_s;
            tx_current_block <= tx_blk_s;
            rx_block_irq     <= rx_irq_p;
            tx_block_irq     <= tx_irq_p;
        end
    end

endmodule
`default_nettype wire

// >>> tb/tmps_checker.sv
`timescale 1ns/1ps
`default_nettype none
// ====================
// Port-level checks of the partition sequencer
module tmps_checker
    import tmps_pkg::*;
(
    input wire logic          sys_clk,
    input wire logic          reset_n,
    input wire logic          bit_clk,
    input wire logic          rx_frame_sync,
    input wire logic          tx_frame_sync,
    input wire tmps_dir_cfg_t rx_cfg,
    input wire tmps_dir_cfg_t tx_cfg,
    input wire tmps_slot_t    rx_slot,
    input wire tmps_slot_t    tx_slot,
    input wire logic          rx_block_irq,
    input wire logic          tx_block_irq
);
    // Frame opens on block 0, or on A's even block
    rx_start_a: assert property (@(posedge bit_clk) disable iff (!reset_n)
        rx_frame_sync |-> ##[1:2] rx_slot.slot_valid && rx_slot.channel ==
        {rx_cfg.partition_count_sel ? 2'h0 : rx_cfg.part_a_block, 5'h00})
        else $error("rx start");
    tx_start_a: assert property (@(posedge bit_clk) disable iff (!reset_n)
        tx_frame_sync |-> ##[1:2] tx_slot.slot_valid && tx_slot.channel ==
        {tx_cfg.partition_count_sel ? 2'h0 : tx_cfg.part_a_block, 5'h00})
        else $error("tx start");
    rx_open_a: assert property (@(posedge bit_clk) disable iff (!reset_n)
        $rose(rx_slot.slot_valid) |-> $past(rx_frame_sync) ||
        $past(rx_frame_sync, 2)) else $error("rx open");
    // One channel at a time through a block
    rx_step_a: assert property (@(posedge bit_clk) disable iff (!reset_n)
        rx_slot.slot_valid && $past(rx_slot.slot_valid) &&
        $changed(rx_slot.channel) |-> rx_slot.channel[3:0] ==
        $past(rx_slot.channel[3:0]) + 4'h1) else $error("rx step");
    // Next block: plus one with eight parts, other partition with two
    rx_next_part_a: assert property (@(posedge bit_clk) disable iff (!reset_n)
        rx_slot.slot_valid && $past(rx_slot.slot_valid) &&
        rx_slot.channel[3:0] == 4'h0 && $past(rx_slot.channel[3:0]) == 4'hF
        |-> rx_slot.channel[6:4] == (rx_cfg.partition_count_sel ?
        $past(rx_slot.channel[6:4]) + 3'h1 : ($past(rx_slot.channel[4]) ?
        {rx_cfg.part_a_block, 1'b0} : {rx_cfg.part_b_block, 1'b1})))
        else $error("rx order");
    rx_all_en_a: assert property (@(posedge bit_clk) disable iff (!reset_n)
        rx_slot.slot_valid && !rx_cfg.multichan_mode[0] |-> rx_slot.enabled)
        else $error("rx all enabled");
    tx_all_a: assert property (@(posedge bit_clk) disable iff (!reset_n)
        tx_slot.slot_valid && tx_cfg.multichan_mode == TX_MODE_ALL
        |-> tx_slot.enabled && tx_slot.unmasked) else $error("tx mode 0");
    tx_mask_a: assert property (@(posedge bit_clk) disable iff (!reset_n)
        tx_slot.slot_valid && !tx_slot.enabled |-> !tx_slot.unmasked)
        else $error("tx mask");
    rx_irq_a: assert property (@(posedge sys_clk) disable iff (!reset_n)
        rx_block_irq |=> !rx_block_irq) else $error("rx event width");
    tx_irq_mode_a: assert property (@(posedge sys_clk) disable iff (!reset_n)
        tx_block_irq |-> tx_cfg.irq_mode == IRQ_MODE_BLOCK)
        else $error("tx event mode");
    rx_eight_c: cover property (@(posedge bit_clk) rx_slot.channel == 7'h7F);
    tx_sym_c: cover property (@(posedge bit_clk)
        tx_slot.slot_valid && tx_cfg.multichan_mode == TX_MODE_SYM);
    rx_irq_c: cover property (@(posedge sys_clk) rx_block_irq);
endmodule
bind tmps_partition_select tmps_checker i_chk (.sys_clk, .reset_n, .bit_clk,
    .rx_frame_sync, .tx_frame_sync, .rx_cfg, .tx_cfg, .rx_slot, .tx_slot,
    .rx_block_irq, .tx_block_irq);
`default_nettype wire

// >>> tb/tmps_frame_peer.sv
`timescale 1ns/1ps
`default_nettype none
// ====================
// Far-side framer: one sync, then one slot end per word
module tmps_frame_peer (
    input  wire logic       bit_clk,
    input  wire logic       start,
    input  wire logic [6:0] frame_length,
    input  wire logic       slow,
    output logic            frame_sync,
    output logic            slot_end,
    output logic            busy
);
    int unsigned n;
    // Slow mode idles a cycle after each word to stretch the slots
    initial
    begin
        {frame_sync, slot_end, busy} = 3'h0;
        forever
        begin
            @(negedge bit_clk);
            if (start)
            begin
                busy       = 1'b1;
                frame_sync = 1'b1;
                @(negedge bit_clk);
                frame_sync = 1'b0;
                for (n = 0; n <= frame_length; n++)
                begin
                    slot_end = 1'b1;
                    @(negedge bit_clk);
                    if (slow)
                    begin
                        slot_end = 1'b0;
                        @(negedge bit_clk);
                    end
                end
                {slot_end, busy} = 2'h0;
            end
        end
    end
endmodule
`default_nettype wire

// >>> tb/tmps_partition_select_test.sv
`timescale 1ns/1ps
`default_nettype none
// ====================
// Frame-level bench of the partition sequencer
module tmps_partition_select_test
    import tmps_pkg::*;
;
    logic          sys_clk, bit_clk, reset_n, start, slow;
    logic          rx_fs, rx_se, rx_busy, tx_fs, tx_se, tx_busy;
    logic          rx_irq, tx_irq, rx_cp, tx_cp, tx_dn;
    logic [2:0]    rx_blk, tx_blk;
    logic [127:0]  rx_en, tx_en;
    logic [31:0]   seed;
    tmps_dir_cfg_t rx_cfg, tx_cfg;
    tmps_slot_t    rx_slot, tx_slot, rx_prev, tx_prev;
    tmps_slot_t    rx_q[$], tx_q[$];
    int            i, rx_irqs, tx_irqs, miscompares, samples_checked;
    // ====================
    // Clocks; link offset keeps its edges off the 4 ns grid
    initial
    begin
        sys_clk = 1'b0;
        forever #2 sys_clk = ~sys_clk;
    end
    initial
    begin
        bit_clk = 1'b0;
        #6.5;
        forever #15 bit_clk = ~bit_clk;
    end
    tmps_partition_select i_dut (.sys_clk, .reset_n, .bit_clk,
        .rx_frame_sync(rx_fs), .rx_slot_end(rx_se), .tx_frame_sync(tx_fs),
        .tx_slot_end(tx_se), .rx_cfg, .tx_cfg, .rx_chan_enable(rx_en),
        .tx_chan_enable(tx_en), .rx_slot, .tx_slot, .rx_copy_allowed(rx_cp),
        .tx_copy_allowed(tx_cp), .tx_drive_n(tx_dn),
        .rx_current_block(rx_blk), .tx_current_block(tx_blk),
        .rx_block_irq(rx_irq), .tx_block_irq(tx_irq));
    tmps_frame_peer i_rx_peer (.bit_clk, .start, .slow,
        .frame_length(rx_cfg.frame_length), .frame_sync(rx_fs),
        .slot_end(rx_se), .busy(rx_busy));
    tmps_frame_peer i_tx_peer (.bit_clk, .start, .slow,
        .frame_length(tx_cfg.frame_length), .frame_sync(tx_fs),
        .slot_end(tx_se), .busy(tx_busy));
    // ====================
    // Helpers
    function automatic logic [31:0] rnd();
        seed ^= seed << 13;
        seed ^= seed >> 17;
        seed ^= seed << 5;
        return seed;
    endfunction
    // Channel of slot s: fixed blocks, or A and B in turn
    function automatic logic [6:0] chan(input tmps_dir_cfg_t c,
                                        input logic [6:0] s);
        return {(c.partition_count_sel ? s[6:4] : s[4] ?
                {c.part_b_block, 1'b1} : {c.part_a_block, 1'b0}), s[3:0]};
    endfunction
    task automatic summarize();
        if (miscompares == 0 && samples_checked > 0)
            $display("Simulation passed");
        else
            $display("Simulation failed");
        $finish;
    endtask
    task automatic check_num(input logic [7:0] got, input logic [7:0] exp);
        samples_checked++;
        if (got !== exp)
        begin
            miscompares++;
            $display("unexpected %0t: %h vs %h", $time, got, exp);
        end
    endtask
    // Slot, copy and drive; rx leaves mask and drive unchecked
    task automatic check_slot(input logic [11:0] got, input logic [11:0] exp,
                              input logic [11:0] care);
        samples_checked++;
        if (((got ^ exp) & care) !== 12'h000)
        begin
            miscompares++;
            $display("unexpected slot %0t: %h vs %h", $time, got, exp);
        end
    endtask
    // A stalled slot repeats, so only a new slot takes a note
    task automatic watch(input tmps_slot_t got, inout tmps_slot_t prev,
                         ref tmps_slot_t q[$], input logic [1:0] aux,
                         input logic [11:0] care);
        tmps_slot_t e;
        if (got.slot_valid === 1'b1 && (prev.slot_valid !== 1'b1 ||
            got.channel !== prev.channel))
        begin
            e = (q.size() > 0) ? q.pop_front() : '0;
            check_slot({got, aux}, {e, e.enabled, !e.unmasked}, care);
        end
        prev = got;
    endtask
    task automatic wait_busy(input logic lvl);
        int n;
        for (n = 0; (rx_busy | tx_busy) !== lvl && n < 20000; n++)
            @(negedge sys_clk);
        if (n >= 20000)
        begin
            miscompares++;
            summarize();
        end
    endtask
    // ====================
    // Monitors
    always @(posedge bit_clk)
    begin
        #1;
        watch(rx_slot, rx_prev, rx_q, {rx_cp, 1'b0}, 12'hFFA);
        watch(tx_slot, tx_prev, tx_q, {tx_cp, tx_dn}, 12'hFFF);
    end
    always @(posedge sys_clk)
    begin
        rx_irqs += (rx_irq === 1'b1);
        tx_irqs += (tx_irq === 1'b1);
    end
    // ====================
    // Config moves only between frames modes and lengths vary
    task automatic run_frame(input int k);
        logic [6:0] lens[4] = '{7'h27, 7'h7F, 7'h00, 7'h0F};
        logic [6:0] ch;
        logic       irq;
        int         s, rx_base, tx_base;
        @(negedge sys_clk);
        irq = (k % 4) != 0;
        rx_cfg = '{1'b0, (k < 4) ? lens[k] : 7'(rnd()), k[0], {1'b0, irq},
                   {1'b0, irq}, 2'(rnd()), 2'(rnd())};
        tx_cfg = '{1'b0, (k < 4) ? lens[k] : 7'(rnd()), k[1], 2'(k % 4),
                   {1'b0, irq}, 2'(rnd()), 2'(rnd())};
        rx_en = {rnd(), rnd(), rnd(), rnd()};
        tx_en = {rnd(), rnd(), rnd(), rnd()};
        slow = (k % 3) == 2;
        for (s = 0; s <= rx_cfg.frame_length; s++)
        begin
            ch = chan(rx_cfg, 7'(s));
            rx_q.push_back({1'b1, ch, rx_en[ch] | !irq, 1'b0});
        end
        for (s = 0; s <= tx_cfg.frame_length; s++)
        begin
            ch = chan(tx_cfg, 7'(s));
            case (tx_cfg.multichan_mode)
                TX_MODE_ENABLE: tx_q.push_back({1'b1, ch, {2{tx_en[ch]}}});
                TX_MODE_MASK:   tx_q.push_back({1'b1, ch, 1'b1, tx_en[ch]});
                TX_MODE_SYM:    tx_q.push_back({1'b1, ch, rx_en[ch],
                                                rx_en[ch] & tx_en[ch]});
                default:        tx_q.push_back({1'b1, ch, 2'b11});
            endcase
        end
        rx_base = rx_irqs;
        tx_base = tx_irqs;
        repeat (4) @(negedge bit_clk);
        @(negedge sys_clk);
        start = 1'b1;
        wait_busy(1'b1);
        start = 1'b0;
        wait_busy(1'b0);
        repeat (4) @(negedge bit_clk);
        check_num(8'(rx_q.size()), 8'h00);
        check_num(8'(tx_q.size()), 8'h00);
        check_num(8'(rx_blk), 8'(chan(rx_cfg, rx_cfg.frame_length) >> 4));
        check_num(8'(tx_blk), 8'(chan(tx_cfg, tx_cfg.frame_length) >> 4));
        check_num(8'(rx_irqs - rx_base), irq ? 8'(rx_cfg.frame_length[6:4]) + 8'h01 : 8'h00);
        check_num(8'(tx_irqs - tx_base), irq ? 8'(tx_cfg.frame_length[6:4]) + 8'h01 : 8'h00);
    endtask
    initial
    begin
        seed = 32'h00000028;
        {miscompares, samples_checked, rx_irqs, tx_irqs} = '0;
        {rx_prev, tx_prev, rx_cfg, tx_cfg, rx_en, tx_en} = '0;
        {start, slow, reset_n} = 3'h0;
        repeat (8) @(negedge bit_clk);
        @(negedge sys_clk);
        reset_n = 1'b1;
        for (i = 0; i < 12; i++)
            run_frame(i);
        summarize();
    end
endmodule
`default_nettype wire
